// ---- design/tpt_defs.vh ----
// constants shared by the trace port transmitter files
// assumes a 200 MHz core clock feeding every register of the block
`ifndef TPT_DEFS_VH
`define TPT_DEFS_VH

// ****************************************************************
// clock rates in MHz
// ****************************************************************
`define TPT_CORE_MHZ 200
`define TPT_STSP_MAX_MHZ 100
`define TPT_PTPU_MAX_MHZ 160

// core cycles per half period of each forwarded clock, rounded up
`define TPT_STSP_HALF_CYC \
  ((`TPT_CORE_MHZ + 2 * `TPT_STSP_MAX_MHZ - 1) / (2 * `TPT_STSP_MAX_MHZ))
`define TPT_PTPU_HALF_CYC \
  ((`TPT_CORE_MHZ + 2 * `TPT_PTPU_MAX_MHZ - 1) / (2 * `TPT_PTPU_MAX_MHZ))

// ****************************************************************
// widths
// ****************************************************************
`define TPT_STSP_LANES 4
`define TPT_STSP_BYTE_W 8
`define TPT_PTPU_WIDE_W 18
`define TPT_PTPU_NARROW_W 16
`define TPT_DIV_W 4

// ****************************************************************
// reset and idle levels
// ****************************************************************
`define TPT_CLK_IDLE 1'h0
`define TPT_NIBBLE_IDLE 4'h0
`define TPT_PTPU_DATA_IDLE 18'h0_0000
`define TPT_PTPU_CTL_IDLE 1'h0
`define TPT_DIV_RESET 4'h0

`endif

// ---- design/tpt_skid_buf.v ----
// two-entry buffer with valid and ready on both sides
// assumes both sides run on i_core_clk; reset is synchronous active low
`timescale 1ns/1ps
`default_nettype none

module tpt_skid_buf #(
  parameter W = 8
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire [W-1:0] i_in_data,
  input wire i_in_valid,
  output reg o_in_ready,
  output wire [W-1:0] o_out_data,
  input wire i_out_ready,
  output reg o_out_valid
);

  // ****************************************************************
  // storage
  // ****************************************************************
  reg [W-1:0] head;
  reg [W-1:0] tail;
  reg [1:0] count;
  reg [1:0] next_count;
  wire push;
  wire pop;

  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign o_out_data = head;

  // occupancy after this cycle
  always @* begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  // flags are registered so the ready reaching the source is a flop
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      count <= 2'h0;
      o_in_ready <= 1'h1;
      o_out_valid <= 1'h0;
      head <= {W{1'b0}};
      tail <= {W{1'b0}};
    end else begin
      count <= next_count;
      o_in_ready <= (next_count != 2'h2);
      o_out_valid <= (next_count != 2'h0);
      if (push && (count == 2'h0 || (pop && count == 2'h1))) begin
        head <= i_in_data;
      end else if (pop) begin
        head <= tail;
      end
      if (push && (count == 2'h1 && !pop || count == 2'h2)) begin
        tail <= i_in_data;
      end
    end
  end

endmodule // tpt_skid_buf

`default_nettype wire

// ---- design/tpt_trace_port_transmitter.v ----
// output side of the two trace ports: serial software trace and
// the wide parallel trace port, each with a forwarded clock
// assumes trace sources on i_core_clk (200 MHz) with valid/ready
//
// What this block does
// - four data lines plus one clock out
// - dual edge: new nibble each clock edge
// - single edge: data valid at falling edge
// - serial clock toggles only while data pending
// - serial forwarded clock at most 100 MHz
// - dual edge data launched from both edges
// - parallel control launched from both edges
// - parallel data launched with control, both edges
// - parallel forwarded clock at most 160 MHz
`timescale 1ns/1ps
`default_nettype none
`include "tpt_defs.vh"

module tpt_trace_port_transmitter (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire [7:0] i_stsp_byte,
  input wire i_stsp_valid,
  output wire o_stsp_ready,
  input wire i_stsp_single_edge,
  output reg o_stsp_clk,
  output reg [3:0] o_stsp_data,
  input wire [17:0] i_ptpu_data,
  input wire i_ptpu_ctl,
  input wire i_ptpu_valid,
  output wire o_ptpu_ready,
  input wire i_ptpu_wide,
  output reg o_ptpu_clk,
  output reg [17:0] o_ptpu_data,
  output reg o_ptpu_ctl
);

  // ****************************************************************
  // rate limits
  // ****************************************************************
  // integer results cut to the divider width on purpose
  localparam integer STSP_HALF_N = `TPT_STSP_HALF_CYC;
  localparam integer PTPU_HALF_N = `TPT_PTPU_HALF_CYC;
  localparam [3:0] STSP_HALF = STSP_HALF_N[3:0];
  localparam [3:0] PTPU_HALF = PTPU_HALF_N[3:0];

  // one-hot serial states, one per half period of the clock
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_RISE1 = 4'h2;
  localparam [3:0] ST_FALL1 = 4'h4;
  localparam [3:0] ST_RISE2 = 4'h8;

  // end of a half period for a divider and its length
  function div_end;
    input [3:0] cnt;
    input [3:0] half;
    begin
      div_end = (cnt == half - 4'h1);
    end
  endfunction

  // next divider count, wrapping at the half period
  function [3:0] div_next;
    input [3:0] cnt;
    input [3:0] half;
    begin
      if (cnt == half - 4'h1) begin
        div_next = `TPT_DIV_RESET;
      end else begin
        div_next = cnt + 4'h1;
      end
    end
  endfunction

  // ****************************************************************
  // serial trace buffer
  // ****************************************************************
  wire [7:0] sbuf_byte;
  wire sbuf_valid;
  reg sbuf_pop;

  tpt_skid_buf #(
    .W(`TPT_STSP_BYTE_W)
  ) u_stsp_buf (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_in_data(i_stsp_byte),
    .i_in_valid(i_stsp_valid),
    .o_in_ready(o_stsp_ready),
    .o_out_data(sbuf_byte),
    .i_out_ready(sbuf_pop),
    .o_out_valid(sbuf_valid)
  );

  // ****************************************************************
  // serial trace engine
  // ****************************************************************
  reg [3:0] st_state;
  reg [3:0] next_st_state;
  reg [3:0] st_div;
  reg st_se_mode;
  reg [3:0] st_hi_nib;
  reg next_clk;
  reg [3:0] next_data;
  wire st_tick;

  // never shorter than one core cycle per half period
  assign st_tick = div_end(st_div, STSP_HALF);

  // a byte goes out low nibble first; the clock always parks low
  always @* begin
    next_st_state = st_state;
    next_clk = o_stsp_clk;
    next_data = o_stsp_data;
    sbuf_pop = 1'b0;
    if (st_tick) begin
      case (st_state)
        ST_IDLE: begin
          // no byte pending: clock and data stay frozen
          if (sbuf_valid) begin
            sbuf_pop = 1'b1;
            next_data = sbuf_byte[3:0];
            next_clk = 1'b1;
            next_st_state = ST_RISE1;
          end
        end
        ST_RISE1: begin
          next_clk = 1'b0;
          if (st_se_mode) begin
            // data held so the falling edge captures it
            next_st_state = ST_FALL1;
          end else begin
            next_data = st_hi_nib;
            next_st_state = ST_IDLE;
          end
        end
        ST_FALL1: begin
          next_data = st_hi_nib;
          next_clk = 1'b1;
          next_st_state = ST_RISE2;
        end
        ST_RISE2: begin
          next_clk = 1'b0;
          next_st_state = ST_IDLE;
        end
        default: begin
          next_clk = `TPT_CLK_IDLE;
          next_st_state = ST_IDLE;
        end
      endcase
    end
  end

  // mode is caught per byte so a change never splits a byte
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st_state <= ST_IDLE;
      st_div <= `TPT_DIV_RESET;
      st_se_mode <= 1'b0;
      st_hi_nib <= `TPT_NIBBLE_IDLE;
      o_stsp_clk <= `TPT_CLK_IDLE;
      o_stsp_data <= `TPT_NIBBLE_IDLE;
    end else begin
      st_state <= next_st_state;
      st_div <= div_next(st_div, STSP_HALF);
      o_stsp_clk <= next_clk;
      o_stsp_data <= next_data;
      if (sbuf_pop) begin
        st_se_mode <= i_stsp_single_edge;
        st_hi_nib <= sbuf_byte[7:4];
      end
    end
  end

  // ****************************************************************
  // parallel trace buffer
  // ****************************************************************
  wire [18:0] pbuf_word;
  wire pbuf_valid;
  wire pbuf_pop;
  wire pt_tick;
  reg [3:0] pt_div;

  tpt_skid_buf #(
    .W(`TPT_PTPU_WIDE_W + 1)
  ) u_ptpu_buf (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_in_data({i_ptpu_ctl, i_ptpu_data}),
    .i_in_valid(i_ptpu_valid),
    .o_in_ready(o_ptpu_ready),
    .o_out_data(pbuf_word),
    .i_out_ready(pbuf_pop),
    .o_out_valid(pbuf_valid)
  );

  // ****************************************************************
  // parallel trace engine
  // ****************************************************************
  // the clock runs free; a word leaves on every edge of it
  assign pt_tick = div_end(pt_div, PTPU_HALF);
  assign pbuf_pop = pt_tick & pbuf_valid;

  // narrow mode drives the top two lines low so the probe sees 16
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pt_div <= `TPT_DIV_RESET;
      o_ptpu_clk <= `TPT_CLK_IDLE;
      o_ptpu_data <= `TPT_PTPU_DATA_IDLE;
      o_ptpu_ctl <= `TPT_PTPU_CTL_IDLE;
    end else begin
      pt_div <= div_next(pt_div, PTPU_HALF);
      if (pt_tick) begin
        o_ptpu_clk <= ~o_ptpu_clk;
        if (pbuf_valid) begin
          o_ptpu_ctl <= pbuf_word[18];
          o_ptpu_data[15:0] <= pbuf_word[15:0];
          o_ptpu_data[17:16] <= i_ptpu_wide ? pbuf_word[17:16] : 2'h0;
        end else begin
          // starved: idle word, still edge aligned
          o_ptpu_ctl <= `TPT_PTPU_CTL_IDLE;
          o_ptpu_data <= `TPT_PTPU_DATA_IDLE;
        end
      end
    end
  end

endmodule // tpt_trace_port_transmitter

`default_nettype wire

// ---- design/tpt_none_placeholder_removed.v ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- bench/tpt_chk.sv ----
// checker for the trace port transmitter ports
// assumes binding onto the top; 200 MHz core clock, sync reset
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module tpt_chk (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_stsp_valid,
  input wire logic o_stsp_ready,
  input wire logic o_stsp_clk,
  input wire logic [3:0] o_stsp_data,
  input wire logic [17:0] i_ptpu_data,
  input wire logic i_ptpu_ctl,
  input wire logic i_ptpu_valid,
  input wire logic o_ptpu_ready,
  input wire logic i_ptpu_wide,
  input wire logic o_ptpu_clk,
  input wire logic [17:0] o_ptpu_data,
  input wire logic o_ptpu_ctl
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  logic [4:0] idle_cnt;
  // cycles since the last serial take, saturating at 31
  always @(posedge i_core_clk) begin
    if (!i_rst_n || (i_stsp_valid && o_stsp_ready)) idle_cnt <= 5'h00;
    else if (idle_cnt != 5'h1f) idle_cnt <= idle_cnt + 5'h01;
  end
  // serial clock high for no more than one core cycle
  property p_s_half;
    o_stsp_clk |=> !o_stsp_clk;
  endproperty
  a_s_half: assert property (p_s_half)
    else $error("serial clock high too long");
  // long idle: clock parked low, data frozen
  property p_s_stop;
    idle_cnt == 5'h1f |-> !o_stsp_clk && $stable(o_stsp_data);
  endproperty
  a_s_stop: assert property (p_s_stop)
    else $error("serial not parked");
  // a taken byte gets the clock moving soon
  property p_s_go;
    i_stsp_valid && o_stsp_ready |-> ##[1:14] $rose(o_stsp_clk);
  endproperty
  a_s_go: assert property (p_s_go)
    else $error("serial clock never started");
  // parallel clock flips every core cycle, well under its limit
  property p_p_rate;
    o_ptpu_clk |=> !o_ptpu_clk ##1 o_ptpu_clk;
  endproperty
  a_p_rate: assert property (p_p_rate)
    else $error("parallel clock rate wrong");
  // control bit leaves two cycles after it is taken
  property p_p_ctl;
    i_ptpu_valid && o_ptpu_ready |-> ##2 o_ptpu_ctl == $past(i_ptpu_ctl, 2);
  endproperty
  a_p_ctl: assert property (p_p_ctl)
    else $error("ctl mismatch");
  // wide words leave whole, in step with the control bit
  property p_p_data;
    i_ptpu_valid && o_ptpu_ready && i_ptpu_wide |->
      ##2 o_ptpu_data == $past(i_ptpu_data, 2);
  endproperty
  a_p_data: assert property (p_p_data)
    else $error("data mismatch");
  // narrow bus keeps its top two lines low
  property p_p_narrow;
    !i_ptpu_wide |-> ##2 o_ptpu_data[17:16] == 2'b00;
  endproperty
  a_p_narrow: assert property (p_p_narrow)
    else $error("narrow top bits set");
  // nothing taken: an all-zero word goes out
  property p_p_idle;
    !(i_ptpu_valid && o_ptpu_ready) |->
      ##2 o_ptpu_data == 18'h0_0000 && !o_ptpu_ctl;
  endproperty
  a_p_idle: assert property (p_p_idle)
    else $error("idle not zero");
endmodule // tpt_chk
bind tpt_trace_port_transmitter tpt_chk chk_u (
  .i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n),
  .i_stsp_valid(i_stsp_valid),
  .o_stsp_ready(o_stsp_ready),
  .o_stsp_clk(o_stsp_clk),
  .o_stsp_data(o_stsp_data),
  .i_ptpu_data(i_ptpu_data),
  .i_ptpu_ctl(i_ptpu_ctl),
  .i_ptpu_valid(i_ptpu_valid),
  .o_ptpu_ready(o_ptpu_ready),
  .i_ptpu_wide(i_ptpu_wide),
  .o_ptpu_clk(o_ptpu_clk),
  .o_ptpu_data(o_ptpu_data),
  .o_ptpu_ctl(o_ptpu_ctl)
);
`default_nettype wire

// ---- bench/tpt_probe.sv ----
// capture probe model for the serial trace port
// assumes it oversamples the forwarded clock with the core clock
`timescale 1ns/1ps
`default_nettype none
// ****
// probe
// ****
module tpt_probe (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_single,
  input wire logic i_lclk,
  input wire logic [3:0] i_ld,
  output logic [7:0] o_byte,
  output logic o_stb
);
  logic last;
  logic half;
  logic [3:0] lo;
  // dual: take a nibble on both edges; single: only on the falling one
  always @(posedge i_core_clk) begin
    o_stb <= 1'b0;
    last <= i_lclk;
    if (!i_rst_n) begin
      last <= 1'b0;
      half <= 1'b0;
    end else if (i_lclk != last && (!i_single || !i_lclk)) begin
      if (!half) lo <= i_ld;
      else o_byte <= {i_ld, lo};
      o_stb <= half;
      half <= !half;
    end
  end
endmodule // tpt_probe
`default_nettype wire

// ---- bench/trace_port_transmitter_test.sv ----
// self-checking bench for the trace port transmitter
// assumes the probe model and the bound checker
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module trace_port_transmitter_test;
  logic clk = 0, rst_n = 0, s_valid = 0, s_single = 0;
  logic p_ctl = 0, p_valid = 0, p_wide = 1;
  logic [7:0] s_byte = 8'h00;
  logic [17:0] p_data = 18'h0_0000;
  logic s_ready, s_clk, p_ready, p_clk, p_oc, pr_stb;
  logic [3:0] s_data;
  logic [17:0] p_od;
  logic [7:0] pr_byte;
  logic [17:0] pe0, pe1;
  logic pc0, pc1;
  logic [31:0] seed = 32'h0000_8ef3;
  logic [7:0] exp_q[$];
  int fail_count = 0, cmp_count = 0;
  tpt_trace_port_transmitter dut_u (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_stsp_byte(s_byte), .i_stsp_valid(s_valid), .o_stsp_ready(s_ready),
    .i_stsp_single_edge(s_single), .o_stsp_clk(s_clk), .o_stsp_data(s_data),
    .i_ptpu_data(p_data), .i_ptpu_ctl(p_ctl), .i_ptpu_valid(p_valid),
    .o_ptpu_ready(p_ready), .i_ptpu_wide(p_wide), .o_ptpu_clk(p_clk),
    .o_ptpu_data(p_od), .o_ptpu_ctl(p_oc));
  tpt_probe pr_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_single(s_single),
    .i_lclk(s_clk), .i_ld(s_data), .o_byte(pr_byte), .o_stb(pr_stb));
  initial forever #2.5 clk = ~clk;
  function logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // parallel word as the probe should see it at either bus width
  function logic [17:0] exp_word(input logic [17:0] d, input logic wide);
    return wide ? d : {2'b00, d[15:0]};
  endfunction
  task check(input logic [17:0] seen, input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // bytes seen by the probe come back in the order they were taken
  always @(negedge clk) begin
    if (pr_stb === 1'b1) check(pr_byte, exp_q.pop_front());
  end
  // whole run is under 1500 cycles; this limit leaves wide margin
  initial begin
    #20000;
    fail_count++;
    end_of_test;
  end
  // serial bursts in both modes, then parallel streams at both widths
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1;
    for (int m = 0; m < 2; m++) begin
      s_single = m[0];
      for (int i = 0; i < 12; i++) begin
        seed = xs(seed);
        s_byte = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : seed[7:0];
        s_valid = 1;
        while (s_ready !== 1'b1) @(negedge clk);
        exp_q.push_back(s_byte);
        @(negedge clk);
      end
      s_valid = 0;
      repeat (40) @(negedge clk);
      check(18'(exp_q.size()), 18'h0_0000);
      repeat (20) begin
        @(negedge clk);
        check({17'h0_0000, s_clk}, 18'h0_0000);
      end
      $display("serial test done, single edge %0d", m);
    end
    for (int w = 0; w < 2; w++) begin
      p_wide = ~w[0];
      // two-stage expectation: a word taken now shows two edges later
      pe0 = 18'h0_0000;
      pe1 = 18'h0_0000;
      pc0 = 1'b0;
      pc1 = 1'b0;
      repeat (150) begin
        check(p_od, pe1);
        check({17'h0_0000, p_oc}, {17'h0_0000, pc1});
        pe1 = pe0;
        pc1 = pc0;
        if (p_ready === 1'b1) begin
          seed = xs(seed);
          p_valid = seed[0];
          p_ctl = seed[1];
          p_data = seed[31:14];
        end
        if (p_valid && p_ready === 1'b1) begin
          pe0 = exp_word(p_data, p_wide);
          pc0 = p_ctl;
        end else begin
          pe0 = 18'h0_0000;
          pc0 = 1'b0;
        end
        @(negedge clk);
      end
      p_valid = 0;
      repeat (4) @(negedge clk);
      check(p_od, 18'h0_0000);
      check({17'h0_0000, p_oc}, 18'h0_0000);
      $display("parallel test done, wide %0d", p_wide);
    end
    end_of_test;
  end
endmodule // trace_port_transmitter_test
`default_nettype wire
